// [logic/rsr_defines.vh]
// rsr_defines.vh: offsets, field positions, reset values and timing counts
// assumes a 50 MHz core clock and byte-wide registers on a plain port
`ifndef RSR_DEFINES_VH
`define RSR_DEFINES_VH
`define RSR_ADDR_W            8
`define RSR_DATA_W            8
`define RSR_OFF_CONV_B_VOLT   8'h07
`define RSR_OFF_LIN_A_CTRL    8'h08
`define RSR_OFF_LIN_B_CTRL    8'h09
`define RSR_OFF_LIN_A_VOLT    8'h0a
`define RSR_OFF_LIN_B_VOLT    8'h0b
`define RSR_OFF_CONV_A_DELAY  8'h0c
`define RSR_OFF_CONV_B_DELAY  8'h0d
`define RSR_OFF_SCALE_SEL     8'h12
`define RSR_RST_CONV_B_VOLT   8'h93
`define RSR_RST_LIN_CTRL      3'h7
`define RSR_RST_LIN_VOLT      5'h0a
`define RSR_RST_CONV_A_DELAY  8'ha0
`define RSR_RST_CONV_B_DELAY  8'h32
`define RSR_RST_SCALE_SEL     2'h0
`define RSR_BIT_DISCHARGE     2
`define RSR_BIT_PIN_QUALIFY   1
`define RSR_BIT_SW_ENABLE     0
`define RSR_BIT_SEL_PWRUP     0
`define RSR_BIT_SEL_PWRDN     1
`define RSR_LIN_VOLT_MAX      5'h19
`define RSR_CONV_B_VOLT_MIN   8'h14
`define RSR_CLK_HZ            50000000
`define RSR_TICK_US           500
`define RSR_TICK_CYCLES       ((`RSR_CLK_HZ / 1000000) * `RSR_TICK_US)
`define RSR_ZERO8             8'h00
`endif

// [logic/rsr_delay_timer.v]
// rsr_delay_timer.v: counts a delay code in 0.5 ms ticks after a start pulse
// assumes tick is a one-cycle enable pulse on the same clock
`timescale 1ns/1ns
module rsr_delay_timer (
  core_clk,
  rst_n,
  tick,
  start,
  code,
  scale,
  done
);
  input        core_clk;
  input        rst_n;
  input        tick;
  input        start;
  input  [3:0] code;
  input        scale;
  output       done;
  reg    [4:0] left_q;
  reg          busy_q;
  reg          done_q;
  assign done = done_q;
  // one step is one tick, or two when scaled: code times 0.5 or 1 ms
  always @(posedge core_clk) begin
    if (!rst_n) begin
      left_q <= 5'h0_0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        if (code == 4'h0) begin
          done_q <= 1'b1;
          busy_q <= 1'b0;
        end else begin
          left_q <= scale ? {code, 1'b0} : {1'b0, code};
          busy_q <= 1'b1;
        end
      end else if (busy_q && tick) begin
        if (left_q == 5'h0_1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        left_q <= left_q - 5'h0_1;
      end
    end
  end
endmodule

// [logic/rsr_regs.v]
// rsr_regs.v: setpoint and enable registers with converter a sequencing
// assumes en_pin is asynchronous and the host uses one-cycle strobes
//
// What this block does
// - converter b codes 0x00-0x13 reserved; 0x14-0x17 give 0.70-0.73 V
// - converter b codes 0x18-0x9d step 5 mV from 0.735 V to 1.4 V
// - converter b codes 0x9e-0xff step 20 mV from 1.42 V to 3.36 V
// - converter b setpoint is 8-bit read/write, reset value 0x93
// - linear control bit 2 applies discharge while that regulator is off
// - linear control bit 1 also requires the enable pin when set
// - linear control bit 0 is the software enable
// - linear setpoint 5 bits, 0x00-0x19 valid, 0x1a-0x1f reserved
// - converter a power-down delay bits 7:4, from enable pin fall
// - converter a power-up delay bits 3:0, from enable pin rise
// - converter a delay resets to power-down 0xa, power-up 0x0
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`include "rsr_defines.vh"
module rsr_regs (
  core_clk,
  rst_n,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  en_pin,
  linear_a_on,
  linear_b_on,
  linear_a_discharge,
  linear_b_discharge,
  linear_a_setpoint,
  linear_b_setpoint,
  converter_b_setpoint,
  converter_a_on,
  reserved_code_err
);
  parameter TICK_CYCLES = `RSR_TICK_CYCLES;
  input                    core_clk;
  input                    rst_n;
  input  [`RSR_ADDR_W-1:0] reg_addr;
  input  [`RSR_DATA_W-1:0] reg_wdata;
  input                    reg_wr;
  input                    reg_rd;
  output [`RSR_DATA_W-1:0] reg_rdata;
  input                    en_pin;
  output                   linear_a_on;
  output                   linear_b_on;
  output                   linear_a_discharge;
  output                   linear_b_discharge;
  output [4:0]             linear_a_setpoint;
  output [4:0]             linear_b_setpoint;
  output [7:0]             converter_b_setpoint;
  output                   converter_a_on;
  output                   reserved_code_err;

  reg  [7:0]  conv_b_volt_q;
  reg  [2:0]  lin_a_ctrl_q;
  reg  [2:0]  lin_b_ctrl_q;
  reg  [4:0]  lin_a_volt_q;
  reg  [4:0]  lin_b_volt_q;
  reg  [7:0]  conv_a_delay_q;
  reg  [7:0]  conv_b_delay_q;
  reg  [1:0]  scale_sel_q;
  reg  [7:0]  rdata_q;
  reg         pin_s1_q;
  reg         pin_s2_q;
  reg         pin_d_q;
  reg  [15:0] tick_cnt_q;
  reg         tick_q;
  reg         conv_a_on_q;
  reg         lin_a_on_q;
  reg         lin_b_on_q;
  reg         lin_a_dis_q;
  reg         lin_b_dis_q;
  reg         err_q;
  reg  [7:0]  rdata_d;
  wire        pin_rise;
  wire        pin_fall;
  wire        up_done;
  wire        dn_done;
  wire        lin_a_on_d;
  wire        lin_b_on_d;

  assign reg_rdata            = rdata_q;
  assign linear_a_on          = lin_a_on_q;
  assign linear_b_on          = lin_b_on_q;
  assign linear_a_discharge   = lin_a_dis_q;
  assign linear_b_discharge   = lin_b_dis_q;
  assign linear_a_setpoint    = lin_a_volt_q;
  assign linear_b_setpoint    = lin_b_volt_q;
  assign converter_b_setpoint = conv_b_volt_q;
  assign converter_a_on       = conv_a_on_q;
  assign reserved_code_err    = err_q;

  // software enable gated by the pin only when qualification is selected
  function lin_enable;
    input [2:0] ctrl;
    input       pin;
    begin
      lin_enable = ctrl[`RSR_BIT_SW_ENABLE] &
                   (pin | ~ctrl[`RSR_BIT_PIN_QUALIFY]);
    end
  endfunction

  assign lin_a_on_d = lin_enable(lin_a_ctrl_q, pin_s2_q);
  assign lin_b_on_d = lin_enable(lin_b_ctrl_q, pin_s2_q);
  assign pin_rise   = pin_s2_q & ~pin_d_q;
  assign pin_fall   = ~pin_s2_q & pin_d_q;

  // enable pin is asynchronous: two flops before any use
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_d_q  <= 1'b0;
    end else begin
      pin_s1_q <= en_pin;
      pin_s2_q <= pin_s1_q;
      pin_d_q  <= pin_s2_q;
    end
  end

  // 0.5 ms timebase shared by both delay timers
  always @(posedge core_clk) begin
    if (!rst_n) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES[15:0] - 16'h0001) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q     <= 1'b0;
    end
  end

  // register writes; reserved bits are simply not stored
  always @(posedge core_clk) begin
    if (!rst_n) begin
      conv_b_volt_q  <= `RSR_RST_CONV_B_VOLT;
      lin_a_ctrl_q   <= `RSR_RST_LIN_CTRL;
      lin_b_ctrl_q   <= `RSR_RST_LIN_CTRL;
      lin_a_volt_q   <= `RSR_RST_LIN_VOLT;
      lin_b_volt_q   <= `RSR_RST_LIN_VOLT;
      conv_a_delay_q <= `RSR_RST_CONV_A_DELAY;
      conv_b_delay_q <= `RSR_RST_CONV_B_DELAY;
      scale_sel_q    <= `RSR_RST_SCALE_SEL;
    end else if (reg_wr) begin
      case (reg_addr)
        `RSR_OFF_CONV_B_VOLT:  conv_b_volt_q  <= reg_wdata;
        `RSR_OFF_LIN_A_CTRL:   lin_a_ctrl_q   <= reg_wdata[2:0];
        `RSR_OFF_LIN_B_CTRL:   lin_b_ctrl_q   <= reg_wdata[2:0];
        `RSR_OFF_LIN_A_VOLT:   lin_a_volt_q   <= reg_wdata[4:0];
        `RSR_OFF_LIN_B_VOLT:   lin_b_volt_q   <= reg_wdata[4:0];
        `RSR_OFF_CONV_A_DELAY: conv_a_delay_q <= reg_wdata;
        `RSR_OFF_CONV_B_DELAY: conv_b_delay_q <= reg_wdata;
        `RSR_OFF_SCALE_SEL:    scale_sel_q    <= reg_wdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // read mux; unmapped addresses and reserved bits read zero
  always @* begin
    rdata_d = `RSR_ZERO8;
    case (reg_addr)
      `RSR_OFF_CONV_B_VOLT:  rdata_d = conv_b_volt_q;
      `RSR_OFF_LIN_A_CTRL:   rdata_d = {5'h0_0, lin_a_ctrl_q};
      `RSR_OFF_LIN_B_CTRL:   rdata_d = {5'h0_0, lin_b_ctrl_q};
      `RSR_OFF_LIN_A_VOLT:   rdata_d = {3'h0, lin_a_volt_q};
      `RSR_OFF_LIN_B_VOLT:   rdata_d = {3'h0, lin_b_volt_q};
      `RSR_OFF_CONV_A_DELAY: rdata_d = conv_a_delay_q;
      `RSR_OFF_CONV_B_DELAY: rdata_d = conv_b_delay_q;
      `RSR_OFF_SCALE_SEL:    rdata_d = {6'h0_0, scale_sel_q};
      default:               rdata_d = `RSR_ZERO8;
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_n)
      rdata_q <= `RSR_ZERO8;
    else if (reg_rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= `RSR_ZERO8;
  end

  rsr_delay_timer u_up (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick_q),
    .start    (pin_rise),
    .code     (conv_a_delay_q[3:0]),
    .scale    (scale_sel_q[`RSR_BIT_SEL_PWRUP]),
    .done     (up_done)
  );

  rsr_delay_timer u_dn (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick_q),
    .start    (pin_fall),
    .code     (conv_a_delay_q[7:4]),
    .scale    (scale_sel_q[`RSR_BIT_SEL_PWRDN]),
    .done     (dn_done)
  );

  // regulator outputs; a late done is ignored if the pin has turned back
  always @(posedge core_clk) begin
    if (!rst_n) begin
      conv_a_on_q <= 1'b0;
      lin_a_on_q  <= 1'b0;
      lin_b_on_q  <= 1'b0;
      lin_a_dis_q <= 1'b0;
      lin_b_dis_q <= 1'b0;
      err_q       <= 1'b0;
    end else begin
      if (up_done && pin_s2_q)
        conv_a_on_q <= 1'b1;
      else if (dn_done && !pin_s2_q)
        conv_a_on_q <= 1'b0;
      lin_a_on_q  <= lin_a_on_d;
      lin_b_on_q  <= lin_b_on_d;
      lin_a_dis_q <= ~lin_a_on_d & lin_a_ctrl_q[`RSR_BIT_DISCHARGE];
      lin_b_dis_q <= ~lin_b_on_d & lin_b_ctrl_q[`RSR_BIT_DISCHARGE];
      // flag only; reserved codes are stored as written
      err_q <= (conv_b_volt_q < `RSR_CONV_B_VOLT_MIN) |
               (lin_a_volt_q > `RSR_LIN_VOLT_MAX) |
               (lin_b_volt_q > `RSR_LIN_VOLT_MAX);
    end
  end
  // the code-to-voltage maps are analog; the setpoint passes through
  // unchanged to the converter
endmodule

// [tb/rsr_regs_monitor.sv]
// rsr_regs_monitor.sv: port-level assertions for the register bank
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ns
module rsr_regs_monitor #(
  parameter TICK_CYCLES = 25000
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       en_pin,
  input wire logic       linear_a_on,
  input wire logic       linear_b_on,
  input wire logic       linear_a_discharge,
  input wire logic       linear_b_discharge,
  input wire logic [4:0] linear_a_setpoint,
  input wire logic [4:0] linear_b_setpoint,
  input wire logic [7:0] converter_b_setpoint,
  input wire logic       converter_a_on,
  input wire logic       reserved_code_err
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  rd_idle_zero_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  dis_a_off_a: assert property (
    !(linear_a_on && linear_a_discharge))
    else $error("discharge applied to running regulator a");
  dis_b_off_a: assert property (
    !(linear_b_on && linear_b_discharge))
    else $error("discharge applied to running regulator b");
  dis_a_write_a: assert property (
    reg_wr && reg_addr == 8'h08 && reg_wdata[2:0] == 3'b100
    |=> ##1 linear_a_discharge && !linear_a_on)
    else $error("discharge missing on stopped regulator a");
  reset_value_a: assert property (
    $rose(rst_n) |-> converter_b_setpoint == 8'h93 &&
    linear_a_setpoint == 5'h0a && linear_b_setpoint == 5'h0a &&
    !converter_a_on)
    else $error("value wrong after reset");
  conv_b_write_a: assert property (
    reg_wr && reg_addr == 8'h07
    |=> converter_b_setpoint == $past(reg_wdata))
    else $error("setpoint b lost");
  lin_a_write_a: assert property (
    reg_wr && reg_addr == 8'h0a
    |=> linear_a_setpoint == $past(reg_wdata[4:0]))
    else $error("lin a lost");
  lin_b_write_a: assert property (
    reg_wr && reg_addr == 8'h0b
    |=> linear_b_setpoint == $past(reg_wdata[4:0]))
    else $error("lin b lost");
  lin_code_err_a: assert property (
    (linear_a_setpoint > 5'h19) [*2] |-> reserved_code_err)
    else $error("reserved code not flagged");
  pin_low_hold_a: assert property (
    !en_pin && !$past(en_pin) && !$past(en_pin, 2) &&
    !$past(en_pin, 3) |-> !$rose(converter_a_on))
    else $error("converter a started with pin low");
  pin_high_hold_a: assert property (
    en_pin && $past(en_pin) && $past(en_pin, 2) &&
    $past(en_pin, 3) |-> !$fell(converter_a_on))
    else $error("converter a stopped with pin high");
  cover property ($rose(converter_a_on));
  cover property ($fell(converter_a_on));
  cover property ($rose(reserved_code_err));
  cover property ($rose(linear_a_discharge));
endmodule
bind rsr_regs rsr_regs_monitor #(.TICK_CYCLES(TICK_CYCLES))
  rsr_regs_monitor_i (.*);

// [tb/rsr_regs_tb_top.sv]
// rsr_regs_tb_top.sv: self-checking bench for the register bank
// assumes a short tick count so sequencing delays finish quickly
`timescale 1ns/1ns
module rsr_regs_tb_top;
  localparam TK = 4;
  logic       core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, en_pin = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdat, reg_rdata, cb;
  logic [4:0] la, lb;
  logic       a_on, b_on, a_dis, b_dis, c_on, err;
  int         fails = 0, check_count = 0, cyc = 0;
  // write flag, address, data, expected readback
  logic [24:0] rows [20] = '{
    {1'b0,8'h07,8'h00,8'h93}, {1'b0,8'h08,8'h00,8'h07},
    {1'b0,8'h09,8'h00,8'h07}, {1'b0,8'h0a,8'h00,8'h0a},
    {1'b0,8'h0b,8'h00,8'h0a}, {1'b0,8'h0c,8'h00,8'ha0},
    {1'b0,8'h0d,8'h00,8'h32}, {1'b0,8'h12,8'h00,8'h00},
    {1'b0,8'h06,8'h00,8'h00}, {1'b1,8'h07,8'h14,8'h14},
    {1'b1,8'h07,8'h9d,8'h9d}, {1'b1,8'h07,8'hff,8'hff},
    {1'b1,8'h08,8'hff,8'h07}, {1'b1,8'h0b,8'hff,8'h1f},
    {1'b1,8'h0a,8'hfb,8'h1b}, {1'b1,8'h0c,8'h5a,8'h5a},
    {1'b1,8'h0d,8'h47,8'h47}, {1'b1,8'h12,8'hff,8'h03},
    {1'b1,8'h30,8'h55,8'h00}, {1'b1,8'h07,8'h9e,8'h9e}};
  rsr_regs #(.TICK_CYCLES(TK)) rsr_regs_i (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .en_pin(en_pin), .linear_a_on(a_on),
    .linear_b_on(b_on), .linear_a_discharge(a_dis), .linear_b_discharge(b_dis),
    .linear_a_setpoint(la), .linear_b_setpoint(lb), .converter_b_setpoint(cb),
    .converter_a_on(c_on), .reserved_code_err(err));
  always #10 core_clk = ~core_clk;
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task cyc_wait(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // converter a must keep its previous state early, and follow the pin once the code runs out
  task dly(input logic p, input int c, input int m);
    @(posedge core_clk);
    en_pin <= p;
    cyc_wait((c - 1) * TK * m);
    chk(c_on, !p);
    cyc_wait(TK * m + 8);
    chk(c_on, p);
  endtask
  task wrap_up;
    $display("checks %0d, failures %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rdat);
      chk(rdat, rows[i][7:0]);
    end
    cyc_wait(3);
    chk(err, 1'b1);
    chk({la, lb}, {5'h1b, 5'h1f});
    chk(cb, 8'h9e);
    wr(8'h0b, 8'h19);
    wr(8'h0a, 8'h00);
    wr(8'h07, 8'h13);
    cyc_wait(3);
    chk(err, 1'b1);
    wr(8'h07, 8'h17);
    cyc_wait(3);
    chk(err, 1'b0);
    chk({la, lb}, {5'h00, 5'h19});
    chk(cb, 8'h17);
    chk({a_on, a_dis, b_on, b_dis}, 4'b0101);
    @(posedge core_clk);
    en_pin <= 1'b1;
    cyc_wait(6);
    chk({a_on, a_dis, b_on, b_dis}, 4'b1010);
    wr(8'h08, 8'h04);
    cyc_wait(2);
    chk({a_on, a_dis}, 2'b01);
    wr(8'h08, 8'h00);
    cyc_wait(2);
    chk(a_dis, 1'b0);
    @(posedge core_clk);
    en_pin <= 1'b0;
    wr(8'h08, 8'h01);
    cyc_wait(6);
    chk({a_on, b_on, b_dis}, 3'b101);
    wr(8'h0c, 8'h23);
    wr(8'h12, 8'h00);
    cyc_wait(60);
    dly(1'b1, 3, 1);
    dly(1'b0, 2, 1);
    wr(8'h12, 8'h03);
    dly(1'b1, 3, 2);
    dly(1'b0, 2, 2);
    // code zero: no ticks; the pin synchroniser, the done flop and the output flop stand between edge and output
    wr(8'h0c, 8'h00);
    @(posedge core_clk);
    en_pin <= 1'b1;
    cyc_wait(5);
    chk(c_on, 1'b1);
    @(posedge core_clk);
    en_pin <= 1'b0;
    cyc_wait(5);
    chk(c_on, 1'b0);
    // second reset mid-run must restore the defaults
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h07, rdat);
    chk(rdat, 8'h93);
    rd(8'h0c, rdat);
    chk(rdat, 8'ha0);
    chk({la, lb}, {5'h0a, 5'h0a});
    chk({a_on, a_dis, c_on}, 3'b010);
    wrap_up();
  end
endmodule
